// ==== psq_defines.svh ====
// Timing constants and dither LFSR seed and taps for the power sequencer
`ifndef PSQ_DEFINES_SVH
`define PSQ_DEFINES_SVH
`define PSQ_CLK_MHZ 250
`define PSQ_EN_OFF_US 65
`define PSQ_RST_DLY_US 2000
`define PSQ_OV_DLY_US 4000
`define PSQ_EN_OFF_CYC (`PSQ_EN_OFF_US * `PSQ_CLK_MHZ)
`define PSQ_RST_DLY_CYC (`PSQ_RST_DLY_US * `PSQ_CLK_MHZ)
`define PSQ_OV_DLY_CYC (`PSQ_OV_DLY_US * `PSQ_CLK_MHZ)
`define PSQ_LFSR_SEED 16'hace1
`define PSQ_LFSR_TAPS 16'hb400
`endif

// ==== psq_pkg.sv ====
// Types shared by the power sequencer
package psq_pkg;
    typedef enum logic [6:0] {
        PSQ_RESET = 7'h01,
        PSQ_OFF = 7'h02,
        PSQ_UP_PRE = 7'h04,
        PSQ_UP_BUCK = 7'h08,
        PSQ_UP_LDO = 7'h10,
        PSQ_RUN = 7'h20,
        PSQ_DOWN = 7'h40
    } psq_state_t;

    typedef struct packed {
        logic pre_regulator;
        logic output_buck;
        logic ldos;
    } psq_rails_t;

    typedef struct packed {
        logic prereg_undervoltage;
        logic prereg_softstart_low;
        logic buck_undervoltage;
        logic buck_softstart_low;
        logic remote_sensor_uv;
        logic local_sensor_uv;
        logic comms_uv;
    } psq_status_t;

    typedef struct packed {
        logic input_uv;
        logic bias_uv;
        logic pump_rail_uv;
        logic bandgap1_uv;
        logic bandgap2_uv;
        logic thermal_shutdown;
        logic pump_rail_ov;
        logic diode_missing;
        logic switch_ilim;
    } psq_faults_t;
endpackage : psq_pkg

// ==== psq_qual_timer.sv ====
// Qualification timer: output rises after input held high for a count
`timescale 1ns/100ps
module psq_qual_timer #(
    parameter int COUNT = 16
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic cond_in,
    output logic qualified_out
);
    localparam int W = $clog2(COUNT + 1);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic q_reg;
    logic q_next;

    initial begin
        if (COUNT < 1) $error("psq_qual_timer: COUNT must be at least 1");
    end

    // Restarts from zero whenever the condition drops
    always_comb begin
        cnt_next = cnt_reg;
        q_next = 1'b0;
        if (!cond_in) begin
            cnt_next = '0;
        end else if (cnt_reg >= W'(COUNT)) begin
            q_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + W'(1);
            q_next = (cnt_reg + W'(1)) >= W'(COUNT);
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_reg <= '0;
            q_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            q_reg <= q_next;
        end
    end

    assign qualified_out = q_reg;

    property p_qual_drop;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        !cond_in |=> !qualified_out;
    endproperty
    a_qual_drop: assert property (p_qual_drop) else $error("timer output stayed after drop");
endmodule : psq_qual_timer

// ==== psq_sequencer.sv ====
// Power rail sequencer, fault reporting and dither gating
`timescale 1ns/100ps
`include "psq_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Either enable high requests power on
// - On request without fault starts startup
// - Enables low 65 us before shutdown
// - Master fault forces reset, rails off
// - Startup: pre-regulator, buck, then LDOs
// - Fixed order; shutdown LDOs, buck, pre-regulator
// - Open-drain reset and power-good outputs
// - Reset released after 2 ms buck good
// - Reset asserted at once on buck undervoltage
// - Buck overvoltage asserts reset after 4 ms
// - Power-good follows LDO undervoltage immediately
// - LDO overvoltage drops power-good after 4 ms
// - Sensor LDO battery short drops power-good now
// - Pseudo-random frequency dither around base
// - Dither off on sync or low input
// - External clock on pin sets frequency
// - Pump undervoltage inhibits PWM; overvoltage latches
// - Master fault is OR of faults
// - Any LDO undervoltage sets combined status
module psq_sequencer
    import psq_pkg::*;
#(
    parameter int EN_OFF_CYC = `PSQ_EN_OFF_CYC,
    parameter int RST_DLY_CYC = `PSQ_RST_DLY_CYC,
    parameter int OV_DLY_CYC = `PSQ_OV_DLY_CYC
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic logic_enable_in,
    input wire logic ignition_enable_in,
    input wire psq_status_t status_in,
    input wire psq_faults_t faults_in,
    input wire logic buck_overvoltage_in,
    input wire logic ldo_overvoltage_in,
    input wire logic remote_sensor_battery_short_in,
    input wire logic sync_clock_present_in,
    input wire logic input_below_dither_min_in,
    output psq_rails_t rails_on_out,
    output psq_state_t mode_out,
    output logic master_fault_reset_out,
    output logic reset_out_n_out,
    output logic reset_out_n_oe_out,
    output logic five_volt_power_good_out,
    output logic five_volt_power_good_oe_out,
    output logic pwm_enable_out,
    output logic use_sync_clock_out,
    output logic dither_enable_out,
    output logic [15:0] dither_code_out
);
    initial begin
        if (EN_OFF_CYC < 1 || RST_DLY_CYC < 1 || OV_DLY_CYC < 1)
            $error("psq_sequencer: delay counts must be at least 1");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers; status resets to undervoltage so no output reads good early
    localparam int NS = 2 + $bits(psq_status_t) + $bits(psq_faults_t) + 5;
    localparam logic [NS-1:0] SYNC_RST = {2'b00, {$bits(psq_status_t){1'b1}}, 14'h0000};
    logic [NS-1:0] sync1_reg;
    logic [NS-1:0] sync2_reg;
    logic [NS-1:0] raw;
    assign raw = {logic_enable_in, ignition_enable_in, status_in, faults_in,
                  buck_overvoltage_in, ldo_overvoltage_in, remote_sensor_battery_short_in,
                  sync_clock_present_in, input_below_dither_min_in};
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1_reg <= SYNC_RST;
            sync2_reg <= SYNC_RST;
        end else begin
            sync1_reg <= raw;
            sync2_reg <= sync1_reg;
        end
    end

    logic en_l;
    logic en_i;
    psq_status_t st;
    psq_faults_t fl;
    logic buck_ov;
    logic ldo_ov;
    logic v5p_short;
    logic sync_present;
    logic vin_low;
    assign {en_l, en_i, st, fl, buck_ov, ldo_ov, v5p_short, sync_present, vin_low} = sync2_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Fault combination
    logic on_request;
    logic any_ldo_undervoltage;
    logic latched_fault_reg;
    logic latched_fault_next;
    logic master_fault_reset;

    assign on_request = en_l | en_i;
    assign any_ldo_undervoltage = st.remote_sensor_uv | st.local_sensor_uv | st.comms_uv;

    // Latched faults clear only by chip reset, as the analog would on power loss
    always_comb begin
        latched_fault_next = latched_fault_reg | fl.pump_rail_ov | fl.diode_missing
                             | fl.switch_ilim;
    end

    assign master_fault_reset = fl.input_uv | fl.bias_uv | fl.pump_rail_uv | fl.bandgap1_uv
                                | fl.bandgap2_uv | fl.thermal_shutdown
                                | latched_fault_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state machine
    localparam int EW = $clog2(EN_OFF_CYC + 1);
    psq_state_t state_reg;
    psq_state_t state_next;
    logic [EW-1:0] off_cnt_reg;
    logic [EW-1:0] off_cnt_next;
    logic off_filtered;

    // Enable-low filter runs in every state so a brief dropout in run is ignored
    always_comb begin
        off_cnt_next = off_cnt_reg;
        if (on_request) begin
            off_cnt_next = '0;
        end else if (off_cnt_reg < EW'(EN_OFF_CYC)) begin
            off_cnt_next = off_cnt_reg + EW'(1);
        end
    end
    assign off_filtered = off_cnt_reg >= EW'(EN_OFF_CYC);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PSQ_RESET: begin
                state_next = PSQ_OFF;
            end
            PSQ_OFF: begin
                if (on_request) state_next = PSQ_UP_PRE;
            end
            PSQ_UP_PRE: begin
                if (!st.prereg_undervoltage && !st.prereg_softstart_low)
                    state_next = PSQ_UP_BUCK;
            end
            PSQ_UP_BUCK: begin
                if (!st.buck_undervoltage && !st.buck_softstart_low)
                    state_next = PSQ_UP_LDO;
            end
            PSQ_UP_LDO: begin
                if (!any_ldo_undervoltage) state_next = PSQ_RUN;
            end
            PSQ_RUN: begin
                if (off_filtered) state_next = PSQ_DOWN;
            end
            PSQ_DOWN: begin
                if (on_request) state_next = PSQ_UP_PRE;
            end
            default: begin
                state_next = PSQ_RESET;
            end
        endcase
        // Startup stages also abort into shutdown when the request goes away
        if ((state_reg == PSQ_UP_PRE || state_reg == PSQ_UP_BUCK || state_reg == PSQ_UP_LDO)
            && off_filtered) begin
            state_next = PSQ_DOWN;
        end
        if (master_fault_reset) state_next = PSQ_RESET;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg <= PSQ_RESET;
            off_cnt_reg <= '0;
            latched_fault_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            off_cnt_reg <= off_cnt_next;
            latched_fault_reg <= latched_fault_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Rail commands; shutdown peels rails off as each lower one reports low
    psq_rails_t rails_reg;
    psq_rails_t rails_next;
    always_comb begin
        rails_next = rails_reg;
        case (state_next)
            PSQ_RESET, PSQ_OFF: rails_next = '0;
            PSQ_UP_PRE: rails_next = '{1'b1, 1'b0, 1'b0};
            PSQ_UP_BUCK: rails_next = '{1'b1, 1'b1, 1'b0};
            PSQ_UP_LDO, PSQ_RUN: rails_next = '{1'b1, 1'b1, 1'b1};
            PSQ_DOWN: begin
                rails_next.ldos = 1'b0;
                if (!rails_reg.ldos && any_ldo_undervoltage) rails_next.output_buck = 1'b0;
                if (!rails_reg.output_buck && st.buck_undervoltage)
                    rails_next.pre_regulator = 1'b0;
            end
            default: rails_next = '0;
        endcase
    end

    psq_state_t mode_reg;
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rails_reg <= '0;
            mode_reg <= PSQ_RESET;
        end else begin
            rails_reg <= rails_next;
            // Shutdown ends in off once the pre-regulator has fallen
            if (state_next == PSQ_DOWN && !rails_next.pre_regulator && st.prereg_undervoltage)
                mode_reg <= PSQ_OFF;
            else
                mode_reg <= state_next;
        end
    end

    assign rails_on_out = rails_reg;
    assign mode_out = mode_reg;
    assign master_fault_reset_out = master_fault_reset;

    ////////////////////////////////////////////////////////////////////////////
    // Fault reporting outputs
    logic buck_good_q;
    logic buck_ov_q;
    logic ldo_ov_q;
    psq_qual_timer #(.COUNT(RST_DLY_CYC)) u_rst_dly (
        .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
        .cond_in(!st.buck_undervoltage), .qualified_out(buck_good_q));
    psq_qual_timer #(.COUNT(OV_DLY_CYC)) u_buck_ov (
        .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
        .cond_in(buck_ov), .qualified_out(buck_ov_q));
    psq_qual_timer #(.COUNT(OV_DLY_CYC)) u_ldo_ov (
        .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
        .cond_in(ldo_ov), .qualified_out(ldo_ov_q));

    logic rst_pull_reg;
    logic rst_pull_next;
    logic pg_pull_reg;
    logic pg_pull_next;
    always_comb begin
        // Undervoltage bypasses the timer output to cut one cycle off the response
        rst_pull_next = st.buck_undervoltage | !buck_good_q | buck_ov_q;
        pg_pull_next = any_ldo_undervoltage | ldo_ov_q | v5p_short;
    end
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_pull_reg <= 1'b1;
            pg_pull_reg <= 1'b1;
        end else begin
            rst_pull_reg <= rst_pull_next;
            pg_pull_reg <= pg_pull_next;
        end
    end
    // Open drain: data is always low, enable pulls the pin
    assign reset_out_n_out = 1'b0;
    assign reset_out_n_oe_out = rst_pull_reg;
    assign five_volt_power_good_out = 1'b0;
    assign five_volt_power_good_oe_out = pg_pull_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Switching control and dither
    logic [15:0] lfsr_reg;
    logic [15:0] lfsr_next;
    logic dither_en;
    assign dither_en = !sync_present && !vin_low;
    always_comb begin
        lfsr_next = lfsr_reg;
        if (dither_en)
            lfsr_next = {lfsr_reg[14:0], ^(lfsr_reg & `PSQ_LFSR_TAPS)};
    end
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) lfsr_reg <= `PSQ_LFSR_SEED;
        else lfsr_reg <= lfsr_next;
    end
    assign dither_code_out = dither_en ? lfsr_reg : 16'h0000;
    assign dither_enable_out = dither_en;
    assign use_sync_clock_out = sync_present;
    assign pwm_enable_out = rails_reg.pre_regulator && !fl.pump_rail_uv;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_fault_reset;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        master_fault_reset |=> (state_reg == PSQ_RESET) ##1 (rails_on_out == '0);
    endproperty
    a_fault_reset: assert property (p_fault_reset) else $error("fault did not force reset");

    property p_start;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (state_reg == PSQ_OFF && on_request && !master_fault_reset) |=> state_reg == PSQ_UP_PRE;
    endproperty
    a_start: assert property (p_start) else $error("startup not begun");

    property p_run_hold;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (state_reg == PSQ_RUN && on_request) |=> state_reg != PSQ_DOWN;
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("shutdown without filter");

    property p_ldo_first;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        rails_on_out.ldos |-> rails_on_out.output_buck && rails_on_out.pre_regulator;
    endproperty
    a_ldo_first: assert property (p_ldo_first) else $error("rail order broken");

    property p_buck_uv;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        st.buck_undervoltage |=> reset_out_n_oe_out;
    endproperty
    a_buck_uv: assert property (p_buck_uv) else $error("reset not asserted on undervoltage");

    property p_v5p_short;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        v5p_short |=> five_volt_power_good_oe_out;
    endproperty
    a_v5p_short: assert property (p_v5p_short) else $error("power-good not dropped on short");

    property p_pg_release;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (!any_ldo_undervoltage && !ldo_ov && !v5p_short) [*2] |=> !five_volt_power_good_oe_out;
    endproperty
    a_pg_release: assert property (p_pg_release) else $error("power-good not released");

    property p_dither_off;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (sync_present || vin_low) |-> !dither_enable_out && dither_code_out == 16'h0000;
    endproperty
    a_dither_off: assert property (p_dither_off) else $error("dither active when disabled");

    property p_pump_uv;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        fl.pump_rail_uv |-> !pwm_enable_out;
    endproperty
    a_pump_uv: assert property (p_pump_uv) else $error("switching during pump undervoltage");
endmodule : psq_sequencer

// ==== psq_rail_model.sv ====
// Regulator stage model: each rail's status clears a while after its enable
`timescale 1ns/100ps
module psq_rail_model
    import psq_pkg::*;
#(
    parameter int RAMP = 10
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire psq_rails_t rails_in,
    input wire logic buck_drop_in,
    input wire logic ldo_drop_in,
    output psq_status_t status_out
);
    int pre_cnt;
    int buck_cnt;
    int ldo_cnt;
    ////////////////////////////////////////////////////////////////////////////////
    // A stage collapses at once when disabled, so the sequencer never sees stale good status
    always @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pre_cnt <= 0;
            buck_cnt <= 0;
            ldo_cnt <= 0;
        end else begin
            pre_cnt <= rails_in.pre_regulator ? ((pre_cnt < RAMP) ? pre_cnt + 1 : pre_cnt) : 0;
            buck_cnt <= rails_in.output_buck ? ((buck_cnt < RAMP) ? buck_cnt + 1 : buck_cnt) : 0;
            ldo_cnt <= rails_in.ldos ? ((ldo_cnt < RAMP) ? ldo_cnt + 1 : ldo_cnt) : 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Soft-start flags clear slightly before the undervoltage flags
    assign status_out = {pre_cnt < RAMP, pre_cnt < RAMP - 2, (buck_cnt < RAMP) || buck_drop_in,
                         buck_cnt < RAMP - 2, (ldo_cnt < RAMP) || ldo_drop_in, ldo_cnt < RAMP,
                         ldo_cnt < RAMP};
endmodule : psq_rail_model

// ==== psq_sequencer_tb.sv ====
// Self-checking testbench of the power sequencer
`timescale 1ns/100ps
module psq_sequencer_tb
    import psq_pkg::*;
;
    logic clk, rst_n, en_logic, en_ign, bshort, sync, vlow, buck_drop, ldo_drop;
    logic [1:0] ov;
    psq_faults_t faults;
    psq_status_t status;
    psq_rails_t rails;
    psq_state_t mode;
    logic mfr, rst_o, rst_oe, pg_o, pg_oe, pwm_en, use_sync, dith_en;
    logic [15:0] dith_code, a;
    int fails, num_checks, n, n1, n2;

    psq_sequencer #(.EN_OFF_CYC(20), .RST_DLY_CYC(50), .OV_DLY_CYC(60)) DUT (
        .ref_clk_in(clk), .arst_n_in(rst_n), .logic_enable_in(en_logic),
        .ignition_enable_in(en_ign), .status_in(status), .faults_in(faults),
        .buck_overvoltage_in(ov[0]), .ldo_overvoltage_in(ov[1]),
        .remote_sensor_battery_short_in(bshort), .sync_clock_present_in(sync),
        .input_below_dither_min_in(vlow), .rails_on_out(rails), .mode_out(mode),
        .master_fault_reset_out(mfr), .reset_out_n_out(rst_o), .reset_out_n_oe_out(rst_oe),
        .five_volt_power_good_out(pg_o), .five_volt_power_good_oe_out(pg_oe),
        .pwm_enable_out(pwm_en), .use_sync_clock_out(use_sync),
        .dither_enable_out(dith_en), .dither_code_out(dith_code));

    psq_rail_model #(.RAMP(10)) u_model (.ref_clk_in(clk), .arst_n_in(rst_n), .rails_in(rails),
        .buck_drop_in(buck_drop), .ldo_drop_in(ldo_drop), .status_out(status));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task in_rng(input int v, input int lo, input int hi, input string what);
        chk({15'h0000, (v >= lo) && (v <= hi)}, 16'h0001, what);
    endtask : in_rng

    // Samples 1 ns after the edge so the design's updates have landed
    task cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc

    function automatic logic [6:0] pick(input int s);
        case (s)
            0: return mode;
            1: return {4'h0, rails};
            2: return {6'h00, rst_oe};
            3: return {6'h00, pg_oe};
            default: return {6'h00, status.buck_undervoltage};
        endcase
    endfunction : pick

    // Bounded wait of 400 cycles; on a hang the task itself counts a mismatch and reports it
    task wait_on(input int s, input logic [6:0] v, output int cnt);
        cnt = 0;
        while (pick(s) !== v && cnt < 400) begin
            cyc(1);
            cnt++;
        end
        if (pick(s) !== v) begin
            fails++;
            $display("BAD %0t wait limit reached on selector %0d", $time, s);
        end
    endtask : wait_on

    task done(input string name);
        $display("test %s finished, checks %0d, mismatches %0d", name, num_checks, fails);
    endtask : done

    task wrap_up;
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        fails++;
        $display("BAD %0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        {rst_n, en_logic, en_ign, bshort, sync, vlow, buck_drop, ldo_drop, ov} = '0;
        faults = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        cyc(3);
        chk(mode, PSQ_OFF, "idle mode");
        chk({rails, rst_oe, pg_oe, rst_o, pg_o}, 7'h0c, "idle outputs");
        done("reset");
        for (int i = 0; i < 6; i++) begin
            @(posedge clk) faults <= 9'h100 >> i;
            cyc(5);
            chk(mfr, 1'b1, "fault or");
            chk({mode, rails}, {PSQ_RESET, 3'h0}, "fault mode");
            @(posedge clk) faults <= '0;
            cyc(5);
            chk(mfr, 1'b0, "fault gone");
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) faults <= 9'h004 >> i;
            cyc(5);
            @(posedge clk) faults <= '0;
            cyc(5);
            chk(mfr, 1'b1, "latched fault");
            @(posedge clk) rst_n <= 1'b0;
            cyc(2);
            @(posedge clk) rst_n <= 1'b1;
            cyc(5);
            chk(mfr, 1'b0, "latch cleared");
        end
        done("faults");
        @(posedge clk) en_ign <= 1'b1;
        wait_on(0, PSQ_UP_PRE, n);
        in_rng(n, 1, 5, "startup begins");
        chk(rails, 3'h4, "pre first");
        wait_on(0, PSQ_UP_BUCK, n);
        chk(rails, 3'h6, "buck next");
        wait_on(4, 7'h00, n);
        wait_on(0, PSQ_UP_LDO, n);
        chk(rails, 3'h7, "ldos last");
        wait_on(0, PSQ_RUN, n1);
        chk({rails, pwm_en}, 4'hf, "run rails");
        wait_on(3, 7'h00, n2);
        in_rng(n2, 0, 4, "power good up");
        wait_on(2, 7'h00, n2);
        in_rng(n + n1 + n2, 50, 56, "reset release delay");
        done("startup");
        @(posedge clk) en_logic <= 1'b1;
        @(posedge clk) en_ign <= 1'b0;
        cyc(40);
        chk(mode, PSQ_RUN, "logic enable holds");
        @(posedge clk) en_logic <= 1'b0;
        cyc(12);
        @(posedge clk) en_logic <= 1'b1;
        cyc(30);
        chk({mode, rails}, {PSQ_RUN, 3'h7}, "short drop ignored");
        done("enable filter");
        @(posedge clk) ldo_drop <= 1'b1;
        wait_on(3, 7'h01, n);
        in_rng(n, 0, 4, "ldo uv drops good");
        @(posedge clk) ldo_drop <= 1'b0;
        wait_on(3, 7'h00, n);
        in_rng(n, 0, 4, "ldo uv clears");
        @(posedge clk) buck_drop <= 1'b1;
        wait_on(2, 7'h01, n);
        in_rng(n, 0, 4, "buck uv asserts reset");
        @(posedge clk) buck_drop <= 1'b0;
        wait_on(2, 7'h00, n);
        in_rng(n, 50, 56, "reset release again");
        done("undervoltage");
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) ov <= 2'h1 << k;
            cyc(30);
            @(posedge clk) ov <= 2'h0;
            cyc(40);
            chk(pick(2 + k), 7'h00, "short overvoltage ignored");
            @(posedge clk) ov <= 2'h1 << k;
            wait_on(2 + k, 7'h01, n);
            in_rng(n, 59, 66, "overvoltage delay");
            @(posedge clk) ov <= 2'h0;
            wait_on(2 + k, 7'h00, n);
            in_rng(n, 0, 60, "overvoltage recovery");
        end
        @(posedge clk) bshort <= 1'b1;
        wait_on(3, 7'h01, n);
        in_rng(n, 0, 4, "battery short");
        @(posedge clk) bshort <= 1'b0;
        wait_on(3, 7'h00, n);
        done("overvoltage");
        chk(dith_en, 1'b1, "dither on");
        a = dith_code;
        cyc(1);
        chk({15'h0000, dith_code === a}, 16'h0000, "dither moves");
        @(posedge clk) sync <= 1'b1;
        cyc(4);
        chk({dith_en, use_sync}, 2'h1, "sync stops dither");
        chk(dith_code, 16'h0000, "sync zeroes dither code");
        @(posedge clk) sync <= 1'b0;
        @(posedge clk) vlow <= 1'b1;
        cyc(4);
        chk({dith_en, use_sync}, 2'h0, "low input stops dither");
        @(posedge clk) vlow <= 1'b0;
        cyc(4);
        chk(dith_en, 1'b1, "dither back");
        done("dither");
        @(posedge clk) faults <= 9'h040;
        cyc(2);
        chk({rails, pwm_en}, 4'he, "pump uv stops pwm");
        cyc(3);
        chk(pwm_en, 1'b0, "pwm stays off");
        @(posedge clk) faults <= '0;
        wait_on(0, PSQ_RUN, n);
        in_rng(n, 1, 200, "restart after fault");
        @(posedge clk) en_logic <= 1'b0;
        wait_on(0, PSQ_DOWN, n);
        in_rng(n, 20, 26, "shutdown delay");
        chk(rails, 3'h6, "ldos off first");
        wait_on(1, 7'h04, n);
        in_rng(n, 1, 20, "buck off next");
        wait_on(0, PSQ_OFF, n);
        in_rng(n, 1, 20, "shutdown ends");
        chk(rails, 3'h0, "all off");
        @(posedge clk) en_ign <= 1'b1;
        wait_on(0, PSQ_RUN, n);
        in_rng(n, 30, 60, "restart from shutdown");
        done("shutdown");
        wrap_up();
    end
endmodule : psq_sequencer_tb
